// >>> bench/lcdr_bus_ctl.sv
// Behavioural bus controller that drives the clock pin and pulls the data pin.
`timescale 1ns/10ps
`default_nettype none
module lcdr_bus_ctl (
   output logic      scl_pin = 1'b1,
   output logic      sda_low = 1'b0,
   input  wire logic sda_line
);
   // start with clock high
   // A nine nanosecond lead-in keeps every pin change off the sampling clock edge.
   task automatic bus_start();
      #9 sda_low = 1'b0;
      #32 scl_pin = 1'b1;
      #32 sda_low = 1'b1;
      #32 scl_pin = 1'b0;
   endtask
   task automatic bus_stop();
      #8 sda_low = 1'b1;
      #32 scl_pin = 1'b1;
      #32 sda_low = 1'b0;
      #40;
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #8 sda_low = ~b[i];
         #32 scl_pin = 1'b1;
         #32 scl_pin = 1'b0;
      end
      #8 sda_low = 1'b0;
      #32 scl_pin = 1'b1;
      #16 ack = ~sda_line;
      #16 scl_pin = 1'b0;
   endtask
endmodule // lcdr_bus_ctl
`default_nettype wire

// >>> bench/lcdr_monitor.sv
// Port checker for the display driver serial target receiver.
`timescale 1ns/10ps
`default_nettype none
module lcdr_monitor #(parameter int PTR_W = 5) (
   input wire logic                sys_clk,
   input wire logic                reset_n,
   input wire logic                scl_in,
   input wire logic                sda_out,
   input wire logic                sda_oe,
   input wire logic                ptr_load,
   input wire logic [PTR_W-1:0]    ptr_value,
   input wire logic                sub_load,
   input wire lcdr_pkg::lcdr_sub_t sub_value,
   input wire logic                cmd_valid,
   input wire logic                ram_valid,
   input wire logic                ram_ready,
   input wire logic [7:0]          ram_data,
   input wire logic [PTR_W-1:0]    data_ptr,
   input wire lcdr_pkg::lcdr_sub_t sub_count
);
   import lcdr_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_ack_open;
      $rose(sda_oe) ##0 !scl_in;
   endsequence
   a_drive_zero: assert property (sda_out == 1'b0) else $error("drive not low");
   a_ack_clk_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("ack late");
   a_ack_held: assert property (s_ack_open |-> sda_oe [*8]) else $error("ack short");
   a_cmd_acked: assert property (cmd_valid |-> $rose(sda_oe)) else $error("cmd no ack");
   a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid) else $error("cmd long");
   a_ptr_load: assert property (ptr_load |=> data_ptr == $past(ptr_value))
      else $error("pointer load lost");
   a_sub_load: assert property (sub_load |=> sub_count == $past(sub_value))
      else $error("counter load lost");
   a_ptr_step: assert property (!ptr_load ##1 $changed(data_ptr) |->
      data_ptr == $past(data_ptr) + 1'b1) else $error("pointer jump");
   a_sub_carry: assert property (!sub_load ##1 $changed(sub_count) |->
      $past(data_ptr) == '1 && data_ptr == '0) else $error("counter jump");
   a_fifo_stand: assert property (ram_valid && !ram_ready |=>
      ram_valid && $stable(ram_data)) else $error("head moved");
endmodule // lcdr_monitor
bind lcdr_target lcdr_monitor #(.PTR_W(PTR_W)) u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ptr_load(ptr_load),
   .ptr_value(ptr_value), .sub_load(sub_load), .sub_value(sub_value), .cmd_valid(cmd_valid),
   .ram_valid(ram_valid), .ram_ready(ram_ready), .ram_data(ram_data),
   .data_ptr(data_ptr), .sub_count(sub_count));
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the display driver serial target receiver.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lcdr_pkg::*;
   logic       sys_clk, reset_n, sel, ptr_load, sub_load, ram_ready, ack;
   logic       sda_out, sda_oe, cmd_valid, ram_valid, scl_pin, sda_low;
   logic [4:0] ptr_value, ram_addr, data_ptr;
   logic [2:0] own;
   logic [7:0] cmd_byte, ram_data;
   lcdr_sub_t  sub_value, sub_count;
   wire logic  sda_line;
   int         failures, n_compared;
   assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   lcdr_target #(.PTR_W(5), .FIFO_DEPTH(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .scl_in(scl_pin), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_strap(sel), .subaddr_strap_bit0(own[0]), .subaddr_strap_bit1(own[1]),
      .subaddr_strap_bit2(own[2]), .ptr_load(ptr_load), .ptr_value(ptr_value),
      .sub_load(sub_load), .sub_value(sub_value), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .ram_valid(ram_valid), .ram_ready(ram_ready),
      .ram_data(ram_data), .ram_addr(ram_addr), .data_ptr(data_ptr), .sub_count(sub_count));
   lcdr_bus_ctl ctl (.scl_pin(scl_pin), .sda_low(sda_low), .sda_line(sda_line));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic xb(input logic [7:0] b, input logic exp);
      ctl.put_byte(b, ack);
      chk("ack", 8'(exp), 8'(ack));
   endtask
   // Waits for the buffer head, compares it, then pops it in one cycle.
   task automatic pop(input logic [7:0] d, input logic [4:0] a);
      int n;
      @(negedge sys_clk);
      for (n = 0; n < 40 && ram_valid !== 1'b1; n++) begin
         @(negedge sys_clk);
      end
      if (n == 40) begin
         failures++;
         stop_test();
      end
      chk("ram_data", d, ram_data);
      chk("ram_addr", 8'(a), 8'(ram_addr));
      @(posedge sys_clk) ram_ready <= 1'b1;
      @(posedge sys_clk) ram_ready <= 1'b0;
   endtask
   task automatic load(input logic [4:0] p, input lcdr_sub_t s);
      @(posedge sys_clk);
      {ptr_load, sub_load} <= 2'b11;
      ptr_value <= p;
      sub_value <= s;
      @(posedge sys_clk);
      {ptr_load, sub_load} <= 2'b00;
   endtask
   task automatic frame_head();
      ctl.bus_start();
      xb(8'h70, 1'b1);
      xb(8'h00, 1'b1);
   endtask
   task automatic t_write();
      chk("sda_oe", 8'h00, 8'(sda_oe));
      chk("sub_count", 8'h00, 8'(sub_count));
      ctl.bus_start();
      xb(8'h70, 1'b1);
      xb(8'h85, 1'b1);
      chk("cmd_byte", 8'h85, cmd_byte);
      xb(8'h05, 1'b1);
      xb(8'ha5, 1'b1);
      xb(8'h3c, 1'b1);
      chk("cmd_byte", 8'h05, cmd_byte);
      ctl.bus_stop();
      pop(8'ha5, 5'h00);
      pop(8'h3c, 5'h01);
   endtask
   task automatic t_refuse();
      ctl.bus_start();
      xb(8'h72, 1'b0);
      xb(8'h80, 1'b0);
      ctl.bus_start();
      xb(8'h71, 1'b0);
      ctl.bus_stop();
      @(posedge sys_clk) sel <= 1'b1;
      ctl.bus_start();
      xb(8'h72, 1'b1);
      xb(8'h00, 1'b1);
      xb(8'h11, 1'b1);
      ctl.bus_stop();
      @(posedge sys_clk) sel <= 1'b0;
      pop(8'h11, 5'h02);
   endtask
   task automatic t_subaddr();
      @(posedge sys_clk) own <= 3'h5;
      load(5'h03, 3'h4);
      frame_head();
      xb(8'h5a, 1'b0);
      ctl.bus_stop();
      chk("data_ptr", 8'h04, 8'(data_ptr));
      chk("sub_count", 8'h04, 8'(sub_count));
      load(5'h03, 3'h5);
      frame_head();
      xb(8'h5b, 1'b1);
      ctl.bus_stop();
      pop(8'h5b, 5'h03);
      @(posedge sys_clk) own <= 3'h0;
   endtask
   task automatic t_wrap_full();
      int i;
      load(5'h1e, 3'h0);
      frame_head();
      xb(8'he0, 1'b1);
      xb(8'he1, 1'b1);
      xb(8'he2, 1'b0);
      ctl.bus_stop();
      chk("sub_count", 8'h01, 8'(sub_count));
      chk("data_ptr", 8'h01, 8'(data_ptr));
      pop(8'he0, 5'h1e);
      pop(8'he1, 5'h1f);
      load(5'h00, 3'h0);
      frame_head();
      for (i = 0; i < 9; i++) begin
         xb(8'(8'h40 + i), i < 8);
      end
      ctl.bus_stop();
      chk("data_ptr", 8'h08, 8'(data_ptr));
      for (i = 0; i < 8; i++) begin
         pop(8'(8'h40 + i), 5'(i));
      end
   endtask
   initial begin
      {reset_n, sel, ptr_load, sub_load, ram_ready} = 5'h00;
      own = 3'h0;
      ptr_value = 5'h00;
      sub_value = 3'h0;
      failures = 0;
      n_compared = 0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (12) @(posedge sys_clk);
      t_write();
      t_refuse();
      t_subaddr();
      t_wrap_full();
      stop_test();
   end
endmodule // testbench
`default_nettype wire

// >>> inc/lcdr_defs.svh
// Constants for the display driver serial target receiver.
`ifndef LCDR_DEFS_SVH
`define LCDR_DEFS_SVH
`define LCDR_ADDR_FIXED    6'h1c
`define LCDR_ADDR_SEL_BIT  1
`define LCDR_RW_BIT        0
`define LCDR_CONT_BIT      7
`define LCDR_BYTE_BITS     4'h8
`define LCDR_CLK_MHZ       250
`define LCDR_FILT_NS       12
`define LCDR_FILT_CYC      ((`LCDR_FILT_NS * `LCDR_CLK_MHZ + 999) / 1000)
`define LCDR_FIFO_DEPTH    8
`define LCDR_PTR_W         5
`define LCDR_SYNC_RST      6'h03
`endif

// >>> inc/lcdr_pkg.sv
// Types for the display driver serial target receiver.
`default_nettype none
package lcdr_pkg;
   typedef enum logic [2:0] {
      LCDR_ST_IDLE   = 3'b000,
      LCDR_ST_ADDR   = 3'b001,
      LCDR_ST_CMD    = 3'b010,
      LCDR_ST_DATA   = 3'b011,
      LCDR_ST_IGNORE = 3'b100
   } lcdr_state_t;
   typedef logic [2:0] lcdr_sub_t;
endpackage
`default_nettype wire

// >>> logic/lcdr_target.sv
// Serial bus target receiver of a segment display driver, with its display data FIFO.
//
// Overview of operation
// - Any number of bytes per frame; each eight-bit byte has one acknowledge clock.
// - When addressed, acknowledge the address and every command byte; display data only as below.
// - Acknowledge by holding data low across the whole ninth clock high phase.
// - Only a target receiver; the only data line output is the acknowledge.
// - Three subaddress straps form a binary subaddress; all low gives zero.
// - Respond to address 0111 000 or 0111 001; bit 1 equals select strap.
// - Never acknowledge an address byte requesting a read.
// - Matching devices acknowledge address together; others ignore the whole transfer.
// - Command bytes follow the address; cleared top flag marks the last command.
// - Every selected device acknowledges every command byte regardless of subaddress.
// - Store display data at the location of data pointer and subaddress counter.
// - Advance data pointer after each display data byte not refused for a full FIFO; subaddress counter advances on pointer wrap.
// - Acknowledge display data only when own subaddress equals subaddress counter.
// - Accept either a stop or a repeated start after the last byte.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Sample one bit per clock pulse on the clock rising edge.
`timescale 1ns/10ps
`include "lcdr_defs.svh"
`default_nettype none

module lcdr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `LCDR_FIFO_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_fill;
   logic             push;
   logic             pop;
   assign in_ready  = (fill < (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fill   = fill;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_fill = fill + 1'b1;
      end else if (pop && !push) begin
         next_fill = fill - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill   <= next_fill;
      end
   end

   // The storage holds no control state and needs no reset.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // lcdr_fifo

module lcdr_target #(
   parameter int PTR_W      = `LCDR_PTR_W,
   parameter int FIFO_DEPTH = `LCDR_FIFO_DEPTH
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe,
   input  wire logic                   addr_select_strap,
   input  wire logic                   subaddr_strap_bit0,
   input  wire logic                   subaddr_strap_bit1,
   input  wire logic                   subaddr_strap_bit2,
   input  wire logic                   ptr_load,
   input  wire logic [PTR_W-1:0]       ptr_value,
   input  wire logic                   sub_load,
   input  wire lcdr_pkg::lcdr_sub_t    sub_value,
   output logic                        cmd_valid,
   output logic      [7:0]             cmd_byte,
   output logic                        ram_valid,
   input  wire logic                   ram_ready,
   output logic      [7:0]             ram_data,
   output logic      [PTR_W-1:0]       ram_addr,
   output logic      [PTR_W-1:0]       data_ptr,
   output lcdr_pkg::lcdr_sub_t         sub_count
);
   import lcdr_pkg::*;
   localparam int FW = 8 + PTR_W;
   localparam logic [3:0] FILT_LAST = 4'(`LCDR_FILT_CYC - 1);

   logic [5:0]  pins;
   logic [5:0]  sync1;
   logic [5:0]  sync2;
   logic [5:0]  next_sync1;
   logic [5:0]  next_sync2;
   logic [1:0]  filt;
   logic [1:0]  prev;
   logic [3:0]  filt_cnt [2];
   lcdr_state_t state;
   lcdr_state_t next_state;
   logic [7:0]  shift;
   logic [7:0]  next_shift;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic        in_ack;
   logic        next_in_ack;
   logic        next_sda_oe;
   logic        next_cmd_valid;
   logic [7:0]  next_cmd_byte;
   logic [PTR_W-1:0] next_data_ptr;
   lcdr_sub_t   next_sub_count;
   logic        push;
   logic        fifo_ready;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_seen;
   logic        stop_seen;
   lcdr_sub_t   own_sub;

   assign pins = {subaddr_strap_bit2, subaddr_strap_bit1, subaddr_strap_bit0,
                  addr_select_strap, sda_in, scl_in};

   always_comb begin
      next_sync1 = pins;
      next_sync2 = sync1;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= `LCDR_SYNC_RST;
         sync2 <= `LCDR_SYNC_RST;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic       next_filt;
         logic [3:0] next_cnt;
         // a line changes only after staying at a new level
         always_comb begin
            next_filt = filt[gi];
            next_cnt  = 4'h0;
            if (sync2[gi] != filt[gi]) begin
               if (filt_cnt[gi] >= FILT_LAST) begin
                  next_filt = sync2[gi];
               end else begin
                  next_cnt = filt_cnt[gi] + 4'h1;
               end
            end
         end
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               filt[gi]     <= 1'b1;
               prev[gi]     <= 1'b1;
               filt_cnt[gi] <= 4'h0;
            end else begin
               filt[gi]     <= next_filt;
               prev[gi]     <= filt[gi];
               filt_cnt[gi] <= next_cnt;
            end
         end
      end
   endgenerate
   assign own_sub  = sync2[5:3];
   assign scl_rise = filt[0] && !prev[0];
   assign scl_fall = !filt[0] && prev[0];
   // start and stop while the clock stays high
   assign start_seen = filt[0] && prev[0] && !filt[1] && prev[1];
   assign stop_seen  = filt[0] && prev[0] && filt[1] && !prev[1];
   // open-drain data line, only ever pulled low
   assign sda_out = 1'b0;
   always_comb begin
      next_state     = state;
      next_shift     = shift;
      next_bit_cnt   = bit_cnt;
      next_in_ack    = in_ack;
      next_sda_oe    = sda_oe;
      next_cmd_valid = 1'b0;
      next_cmd_byte  = cmd_byte;
      next_data_ptr  = data_ptr;
      next_sub_count = sub_count;
      push           = 1'b0;
      if (ptr_load) begin
         next_data_ptr = ptr_value;
      end
      if (sub_load) begin
         next_sub_count = sub_value;
      end
      if (start_seen || stop_seen) begin
         // repeated start begins a new access
         next_state   = start_seen ? LCDR_ST_ADDR : LCDR_ST_IDLE;
         next_bit_cnt = 4'h0;
         next_in_ack  = 1'b0;
         next_sda_oe  = 1'b0;
      end else if (state != LCDR_ST_IDLE) begin
         if (scl_rise && !in_ack && bit_cnt != `LCDR_BYTE_BITS) begin
            next_shift   = {shift[6:0], filt[1]};
            next_bit_cnt = bit_cnt + 4'h1;
         end else if (scl_fall && in_ack) begin
            // release after the ninth clock falls
            next_in_ack  = 1'b0;
            next_sda_oe  = 1'b0;
            next_bit_cnt = 4'h0;
         end else if (scl_fall && bit_cnt == `LCDR_BYTE_BITS) begin
            // every byte is followed by an acknowledge clock
            next_in_ack = 1'b1;
            case (state)
               LCDR_ST_ADDR: begin
                  if (shift[7:2] == `LCDR_ADDR_FIXED &&
                      shift[`LCDR_ADDR_SEL_BIT] == sync2[2] &&
                      !shift[`LCDR_RW_BIT]) begin
                     next_sda_oe = 1'b1;
                     next_state  = LCDR_ST_CMD;
                  end else begin
                     next_state  = LCDR_ST_IGNORE;
                  end
               end
               LCDR_ST_CMD: begin
                  next_sda_oe    = 1'b1;
                  next_cmd_valid = 1'b1;
                  next_cmd_byte  = shift;
                  // cleared flag ends the command phase
                  if (!shift[`LCDR_CONT_BIT]) begin
                     next_state = LCDR_ST_DATA;
                  end
               end
               LCDR_ST_DATA: begin
                  if (own_sub == sub_count) begin
                     // store at pointer when the FIFO has room
                     push        = fifo_ready;
                     next_sda_oe = fifo_ready;
                  end
                  if (own_sub != sub_count || fifo_ready) begin
                     next_data_ptr = data_ptr + 1'b1;
                     if (data_ptr == {PTR_W{1'b1}}) begin
                        next_sub_count = sub_count + 3'h1;
                     end
                  end
               end
               default: begin
                  next_sda_oe = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= LCDR_ST_IDLE;
         shift     <= 8'h00;
         bit_cnt   <= 4'h0;
         in_ack    <= 1'b0;
         sda_oe    <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_byte  <= 8'h00;
         data_ptr  <= '0;
         sub_count <= 3'h0;
      end else begin
         state     <= next_state;
         shift     <= next_shift;
         bit_cnt   <= next_bit_cnt;
         in_ack    <= next_in_ack;
         sda_oe    <= next_sda_oe;
         cmd_valid <= next_cmd_valid;
         cmd_byte  <= next_cmd_byte;
         data_ptr  <= next_data_ptr;
         sub_count <= next_sub_count;
      end
   end

   logic [FW-1:0] fifo_out;

   lcdr_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   ({data_ptr, shift}),
      .out_valid (ram_valid),
      .out_ready (ram_ready),
      .out_data  (fifo_out)
   );

   assign ram_data = fifo_out[7:0];
   assign ram_addr = fifo_out[FW-1:8];
endmodule // lcdr_target

`default_nettype wire
